// [verilog/poe_fault_pkg.sv]
package poe_fault_pkg;
    // Port count, counter and field widths
    localparam int            NPORT          = 4;
    localparam int            CNT_W          = 24;          // Timer counter width
    localparam int            CLAMP_FIELD_W  = 4;           // Clamp duration field width
    // Register indices (byte address is four times the index)
    localparam logic [5:0]    IDX_SUMMARY    = 6'h00;
    localparam logic [5:0]    IDX_MASK       = 6'h01;
    localparam logic [5:0]    IDX_FAULT      = 6'h06;
    localparam logic [5:0]    IDX_FAULT_RC   = 6'h07;
    localparam logic [5:0]    IDX_START      = 6'h08;
    localparam logic [5:0]    IDX_START_RC   = 6'h09;
    localparam logic [5:0]    IDX_CLAMP12    = 6'h1E;
    localparam logic [5:0]    IDX_CLAMP34    = 6'h1F;
    // Summary bit positions
    localparam int            SUM_DIS_BIT    = 2;
    localparam int            SUM_TRIP_BIT   = 5;
    localparam int            SUM_START_BIT  = 6;
    // Field positions inside the event registers
    localparam int            LO_NIB         = 0;
    localparam int            HI_NIB         = 4;
    // Reset values
    localparam logic [7:0]    FLAGS_RST      = 8'h00;
    localparam logic [7:0]    MASK_RST       = 8'h00;
    localparam logic [7:0]    CLAMP_RST      = 8'h00;
    // Clock and timing defaults
    localparam int            CLK_MHZ        = 25;
    localparam int            TRIP_TIME_US   = 50000;       // overload_trip_time
    localparam int            UNPLUG_TIME_US = 300000;      // unplug_detect_time
    localparam int            INRUSH_TIME_US = 50000;       // inrush_window_time
    localparam int            CLAMP_STEP_US  = 1000;        // One step of a clamp field

    // Microseconds to whole clock cycles, never below one
    function automatic int us_to_cycles(input int us);
        int c;
        c = us * CLK_MHZ;
        return (c < 1) ? 1 : c;
    endfunction
endpackage

// [verilog/monitor_if.sv]
`timescale 1ns/100ps
// Synchronised port monitor indications, one bit per port
interface monitor_if;
    logic [3:0] powered;       // Port is powered
    logic [3:0] starting;      // Port is being turned on
    logic [3:0] over_trip;     // Current above overload_trip_current
    logic [3:0] under_unplug;  // Current below the unplug threshold
    logic [3:0] over_inrush;   // Current above the start-up current
    logic [3:0] at_clamp;      // Current held at current_clamp_level
    modport source (output powered, starting, over_trip, under_unplug, over_inrush, at_clamp);
    modport sink   (input  powered, starting, over_trip, under_unplug, over_inrush, at_clamp);
endinterface

// [verilog/monitor_sync.sv]
`timescale 1ns/100ps
module monitor_sync (
    // Clock, reset, enable
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    // Raw monitor pins
    input  wire logic [3:0] powered_pin,
    input  wire logic [3:0] starting_pin,
    input  wire logic [3:0] over_trip_pin,
    input  wire logic [3:0] under_unplug_pin,
    input  wire logic [3:0] over_inrush_pin,
    input  wire logic [3:0] at_clamp_pin,
    // Synchronised view
    monitor_if.source       mon
);
    logic [23:0] raw;       // All pins side by side
    logic [23:0] meta_q;    // First stage, read only by the second
    logic [23:0] meta_d;
    logic [23:0] sync_q;    // Second stage, safe to use
    logic [23:0] sync_d;

    assign raw = {at_clamp_pin, over_inrush_pin, under_unplug_pin,
                  over_trip_pin, starting_pin, powered_pin};

    // Next values: shift by one stage when enabled
    always_comb begin
        meta_d = meta_q;
        sync_d = sync_q;
        if (ce) begin
            meta_d = raw;
            sync_d = meta_q;
        end
    end

    // Two flip-flops per pin against metastability
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= 24'h000000;
            sync_q <= 24'h000000;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign {mon.at_clamp, mon.over_inrush, mon.under_unplug,
            mon.over_trip, mon.starting, mon.powered} = sync_q;
endmodule

// [verilog/fault_timer.sv]
`timescale 1ns/100ps
module fault_timer #(
    parameter int W = 24
) (
    // Clock, reset, enable
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    // Condition and its allowed duration in cycles
    input  wire logic         cond,
    input  wire logic [W-1:0] limit,
    // One-cycle event when the condition outlasts the limit
    output logic              fire
);
    logic [W-1:0] cnt_q;    // Cycles the condition has held
    logic [W-1:0] cnt_d;
    logic         done_q;   // Event already given for this episode
    logic         done_d;
    logic         fire_q;
    logic         fire_d;

    // Next values: count while held, fire once past the limit
    always_comb begin
        cnt_d  = cnt_q;
        done_d = done_q;
        fire_d = 1'b0;
        if (!cond) begin
            // Condition gone: restart the episode
            cnt_d  = '0;
            done_d = 1'b0;
        end else if (cnt_q < limit) begin
            cnt_d = cnt_q + 1'b1;
        end else if (!done_q) begin
            // Compare with >= so a lowered limit still fires
            fire_d = 1'b1;
            done_d = 1'b1;
        end
    end

    // State registers, frozen while ce is low
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
            fire_q <= 1'b0;
        end else if (ce) begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
            fire_q <= fire_d;
        end
    end

    assign fire = fire_q;
endmodule

// [verilog/poe_port_fault_event_flags.sv]
// Overview of operation
// (R01) Overcurrent past trip time sets fault low nibble
// (R02) Current below unplug threshold sets fault high nibble
// (R03) Fault register read leaves flags unchanged
// (R04) Clearing fault view mirrors, read clears both
// (R05) Fault bits: trip ports 0-3, unplug 4-7
// (R06) Start-up overcurrent past window sets start flag
// (R07) Clamp timeout sets start register high nibble
// (R08) Clamp duration per port from own field
// (R09) Start bits: inrush ports 0-3, clamp 4-7
// (R10) Start register read leaves flags unchanged
// (R11) Clearing start view mirrors, read clears both
// (R12) Summary dis from trip, trip from unplug
// (R13) Summary bit six from any start flag
// (R14) Interrupt pin low only for masked-in summary
// (R15) Flags sticky until clearing read; reset clears
// (R16) Event in clearing-read cycle stays set
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
module poe_port_fault_event_flags
    import poe_fault_pkg::*;
#(
    parameter int TRIP_US   = poe_fault_pkg::TRIP_TIME_US,
    parameter int UNPLUG_US = poe_fault_pkg::UNPLUG_TIME_US,
    parameter int INRUSH_US = poe_fault_pkg::INRUSH_TIME_US,
    parameter int STEP_US   = poe_fault_pkg::CLAMP_STEP_US
) (
    // Clock, reset, enable
    input  wire logic                            ref_clk,
    input  wire logic                            sys_rst,
    input  wire logic                            ce,
    // Classic Wishbone slave
    input  wire logic                            wb_cyc_i,
    input  wire logic                            wb_stb_i,
    input  wire logic                            wb_we_i,
    input  wire logic [7:0]                      wb_adr_i,
    input  wire logic [3:0]                      wb_sel_i,
    input  wire logic [31:0]                     wb_dat_i,
    output logic      [31:0]                     wb_dat_o,
    output logic                                 wb_ack_o,
    // Port monitor pins, asynchronous
    input  wire logic [poe_fault_pkg::NPORT-1:0] powered_pin,
    input  wire logic [poe_fault_pkg::NPORT-1:0] starting_pin,
    input  wire logic [poe_fault_pkg::NPORT-1:0] over_trip_pin,
    input  wire logic [poe_fault_pkg::NPORT-1:0] under_unplug_pin,
    input  wire logic [poe_fault_pkg::NPORT-1:0] over_inrush_pin,
    input  wire logic [poe_fault_pkg::NPORT-1:0] at_clamp_pin,
    // Port switch-off requests
    output logic      [poe_fault_pkg::NPORT-1:0] port_off,
    // Interrupt
    output logic                                 irq,
    output logic                                 irq_n
);
    import poe_fault_pkg::*;

    // Timer limits in cycles, derived from the times
    localparam int TRIP_CYC   = us_to_cycles(TRIP_US);
    localparam int UNPLUG_CYC = us_to_cycles(UNPLUG_US);
    localparam int INRUSH_CYC = us_to_cycles(INRUSH_US);
    localparam int STEP_CYC   = us_to_cycles(STEP_US);

    localparam logic [CNT_W-1:0] TRIP_LIM   = CNT_W'(TRIP_CYC);
    localparam logic [CNT_W-1:0] UNPLUG_LIM = CNT_W'(UNPLUG_CYC);
    localparam logic [CNT_W-1:0] INRUSH_LIM = CNT_W'(INRUSH_CYC);

    // Clamp duration: field value n allows n+1 steps
    function automatic logic [CNT_W-1:0] clamp_cycles(input logic [CLAMP_FIELD_W-1:0] f);
        int c;
        c = (int'(f) + 1) * STEP_CYC;
        return CNT_W'(c);
    endfunction

    // Synchronised monitor bundle
    monitor_if mon ();

    // Bus state
    logic [5:0]  idx;            // Word index of the access
    logic        req_new;        // First cycle of a request
    logic        rd_take;        // Read answered at this edge
    logic        wr_take;        // Write taken at this edge
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdat_q;         // Read data, registered
    logic [31:0] rdat_d;

    // Software-steered registers
    logic [7:0]  mask_q;         // Interrupt mask, summary layout
    logic [7:0]  mask_d;
    logic [7:0]  clamp12_q;      // Clamp fields for ports 1 and 2
    logic [7:0]  clamp12_d;
    logic [7:0]  clamp34_q;      // Clamp fields for ports 3 and 4
    logic [7:0]  clamp34_d;

    // Event flags, shared by plain and clearing views
    logic [7:0]  fault_q;
    logic [7:0]  fault_d;
    logic [7:0]  start_q;
    logic [7:0]  start_d;

    // Timer events per port
    logic [NPORT-1:0] trip_fire;
    logic [NPORT-1:0] unplug_fire;
    logic [NPORT-1:0] inrush_fire;
    logic [NPORT-1:0] clamp_fire;
    logic [CNT_W-1:0] clamp_lim [NPORT];

    // Outputs registered
    logic [NPORT-1:0] off_q;
    logic [NPORT-1:0] off_d;
    logic        irq_q;
    logic        irq_d;
    logic [7:0]  summary;        // Summary register view

    // Pin synchroniser
    monitor_sync u_sync (
        .ref_clk          (ref_clk),
        .sys_rst          (sys_rst),
        .ce               (ce),
        .powered_pin      (powered_pin),
        .starting_pin     (starting_pin),
        .over_trip_pin    (over_trip_pin),
        .under_unplug_pin (under_unplug_pin),
        .over_inrush_pin  (over_inrush_pin),
        .at_clamp_pin     (at_clamp_pin),
        .mon              (mon)
    );

    // Each port owns its clamp field
    assign clamp_lim[0] = clamp_cycles(clamp12_q[3:0]);  // R08
    assign clamp_lim[1] = clamp_cycles(clamp12_q[7:4]);  // R08
    assign clamp_lim[2] = clamp_cycles(clamp34_q[3:0]);  // R08
    assign clamp_lim[3] = clamp_cycles(clamp34_q[7:4]);  // R08

    // Four timers per port, one for each kind of shutdown
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        // Powered port above the trip current
        fault_timer #(.W(CNT_W)) u_trip (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst),
            .ce      (ce),
            .cond    (mon.powered[p] & mon.over_trip[p]),  // R01
            .limit   (TRIP_LIM),
            .fire    (trip_fire[p])
        );
        // Powered port below the unplug threshold
        fault_timer #(.W(CNT_W)) u_unplug (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst),
            .ce      (ce),
            .cond    (mon.powered[p] & mon.under_unplug[p]),  // R02
            .limit   (UNPLUG_LIM),
            .fire    (unplug_fire[p])
        );
        // Turn-on phase above the start-up current
        fault_timer #(.W(CNT_W)) u_inrush (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst),
            .ce      (ce),
            .cond    (mon.starting[p] & mon.over_inrush[p]),  // R06
            .limit   (INRUSH_LIM),
            .fire    (inrush_fire[p])
        );
        // Port held at the clamp level
        fault_timer #(.W(CNT_W)) u_clamp (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst),
            .ce      (ce),
            .cond    (mon.powered[p] & mon.at_clamp[p]),  // R07
            .limit   (clamp_lim[p]),
            .fire    (clamp_fire[p])
        );
    end

    // Bus decode: a new request is answered one cycle later
    assign idx     = wb_adr_i[7:2];
    assign req_new = wb_cyc_i & wb_stb_i & ~ack_q;
    assign rd_take = req_new & ~wb_we_i;
    assign wr_take = req_new & wb_we_i & wb_sel_i[0];

    // Summary derived live from the flags
    always_comb begin
        summary                = 8'h00;
        summary[SUM_DIS_BIT]   = |fault_q[LO_NIB +: NPORT];  // R12
        summary[SUM_TRIP_BIT]  = |fault_q[HI_NIB +: NPORT];  // R12
        summary[SUM_START_BIT] = |start_q;                   // R13
    end

    // Read multiplexer; unmapped words read as zero
    function automatic logic [31:0] reg_read(input logic [5:0] i);
        logic [7:0] v;
        v = 8'h00;
        unique case (i)
            IDX_SUMMARY:  v = summary;
            IDX_MASK:     v = mask_q;
            IDX_FAULT:    v = fault_q;  // R03
            IDX_FAULT_RC: v = fault_q;  // R04
            IDX_START:    v = start_q;  // R10
            IDX_START_RC: v = start_q;  // R11
            IDX_CLAMP12:  v = clamp12_q;
            IDX_CLAMP34:  v = clamp34_q;
            default:      v = 8'h00;
        endcase
        return {24'h000000, v};
    endfunction

    // Next bus state: ack one cycle, data latched with it
    always_comb begin
        ack_d  = req_new;
        rdat_d = rdat_q;
        if (rd_take) begin
            rdat_d = reg_read(idx);
        end
    end

    // Next control registers: low byte lane only
    always_comb begin
        mask_d    = mask_q;
        clamp12_d = clamp12_q;
        clamp34_d = clamp34_q;
        if (wr_take) begin
            unique case (idx)
                IDX_MASK:    mask_d    = wb_dat_i[7:0];
                IDX_CLAMP12: clamp12_d = wb_dat_i[7:0];  // R08
                IDX_CLAMP34: clamp34_d = wb_dat_i[7:0];  // R08
                default:     mask_d    = mask_q;  // Other words ignore writes
            endcase
        end
    end

    // Next flags: only the clearing views clear; new events win
    always_comb begin
        logic [7:0] fault_set;
        logic [7:0] start_set;
        logic       fault_clr;
        logic       start_clr;
        fault_set = {unplug_fire, trip_fire};      // R05
        start_set = {clamp_fire, inrush_fire};     // R09
        fault_clr = rd_take & (idx == IDX_FAULT_RC);  // R04
        start_clr = rd_take & (idx == IDX_START_RC);  // R11
        fault_d   = fault_q;                       // R15
        start_d   = start_q;                       // R15
        if (fault_clr) begin
            fault_d = 8'h00;
        end
        if (start_clr) begin
            start_d = 8'h00;
        end
        // Set after clear so a same-cycle event survives the read
        fault_d = fault_d | fault_set;  // R16
        start_d = start_d | start_set;  // R16
    end

    // Next outputs: switch-off pulse and masked interrupt
    always_comb begin
        off_d = trip_fire | unplug_fire | inrush_fire | clamp_fire;  // R01
        irq_d = |(summary & mask_q);  // R14
    end

    // Registers; ce low freezes everything, bus included
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q     <= 1'b0;
            rdat_q    <= 32'h00000000;
            mask_q    <= MASK_RST;
            clamp12_q <= CLAMP_RST;
            clamp34_q <= CLAMP_RST;
            fault_q   <= FLAGS_RST;  // R15
            start_q   <= FLAGS_RST;  // R15
            off_q     <= '0;
            irq_q     <= 1'b0;
        end else if (ce) begin
            ack_q     <= ack_d;
            rdat_q    <= rdat_d;
            mask_q    <= mask_d;
            clamp12_q <= clamp12_d;
            clamp34_q <= clamp34_d;
            fault_q   <= fault_d;
            start_q   <= start_d;
            off_q     <= off_d;
            irq_q     <= irq_d;
        end
    end

    // Port outputs
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign port_off = off_q;
    assign irq      = irq_q;
    assign irq_n    = ~irq_q;  // R14
endmodule

// [sim/poe_fault_event_assertions.sv]
`timescale 1ns/100ps
// Port-level checker for the fault event flag block
module poe_fault_event_assertions
    import poe_fault_pkg::*;
(
    // Clock and reset
    input wire logic                            ref_clk,
    input wire logic                            sys_rst,
    input wire logic                            ce,
    // Register bus
    input wire logic                            wb_cyc_i,
    input wire logic                            wb_stb_i,
    input wire logic                            wb_we_i,
    input wire logic [7:0]                      wb_adr_i,
    input wire logic [3:0]                      wb_sel_i,
    input wire logic [31:0]                     wb_dat_i,
    input wire logic [31:0]                     wb_dat_o,
    input wire logic                            wb_ack_o,
    // Switch-off requests and interrupt
    input wire logic [poe_fault_pkg::NPORT-1:0] port_off,
    input wire logic                            irq,
    input wire logic                            irq_n
);
    logic       take;   // Request taken at this edge
    logic [7:0] mask_q; // Shadow of the mask register
    logic [7:0] mask_d; // Next shadow value
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
    // Mirror mask writes so interrupt gating can be judged from the pins alone
    always_comb begin
        mask_d = mask_q;
        if (take && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == IDX_MASK) begin
            mask_d = wb_dat_i[7:0];
        end
    end
    // Shadow register, cleared with the design
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_q <= MASK_RST;
        end else begin
            mask_q <= mask_d;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stayed high");
    ack_answer_a: assert property (take |=> wb_ack_o)
        else $error("no ack one cycle after request");
    reset_quiet_a: assert property ($fell(sys_rst) |-> !wb_ack_o && !irq && port_off == '0)
        else $error("outputs active after reset");
    irq_pin_a: assert property (irq_n == !irq)
        else $error("interrupt pin not inverse of irq");
    irq_gate_a: assert property (irq |-> $past(mask_q) != 8'h00)
        else $error("irq with all events masked");
    irq_raise_a: assert property (port_off != '0 && mask_q == 8'hFF |=> irq)
        else $error("unmasked event gave no irq");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h3F
        |-> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    clear_read_a: assert property ((wb_ack_o && !wb_we_i && wb_adr_i[7:2] == IDX_FAULT_RC
        && port_off == '0) ##1 (port_off == '0) [*2]
        ##1 (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == IDX_FAULT) |-> wb_dat_o[7:0] == 8'h00)
        else $error("fault flags survived clearing read");
endmodule

bind poe_port_fault_event_flags poe_fault_event_assertions i_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_off(port_off), .irq(irq), .irq_n(irq_n)
);

// [sim/tb.sv]
`timescale 1ns/100ps
// Self-checking bench for the fault event flag block
module tb;
    import poe_fault_pkg::*;
    localparam int CYC_US = CLK_MHZ; // Cycles in one shortened microsecond
    logic        ref_clk = 1'b0;     // 25 MHz clock
    logic        sys_rst = 1'b1;     // Async reset, high
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, irq, irq_n;
    logic [3:0]  port_off;
    logic [3:0]  powered_pin = 4'h0, starting_pin = 4'h0, over_trip_pin = 4'h0;
    logic [3:0]  under_unplug_pin = 4'h0, over_inrush_pin = 4'h0, at_clamp_pin = 4'h0;
    int          fail_count = 0; // Mismatches
    int          cmp_count = 0;  // Comparisons
    logic [7:0]  rd, rd2;        // Read results
    logic        ce = 1'b1;      // Clock enable
    logic [3:0]  off_seen = 4'h0; // Ports switched off so far
    // Clock
    always #20 ref_clk = ~ref_clk;
    // Gather one-cycle switch-off pulses so none is missed between checks
    always @(posedge ref_clk) off_seen <= off_seen | port_off;
    // Short limits keep every timeout within a few hundred cycles
    poe_port_fault_event_flags #(.TRIP_US(1), .UNPLUG_US(2), .INRUSH_US(1), .STEP_US(1)) i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .powered_pin(powered_pin), .starting_pin(starting_pin), .over_trip_pin(over_trip_pin),
        .under_unplug_pin(under_unplug_pin), .over_inrush_pin(over_inrush_pin),
        .at_clamp_pin(at_clamp_pin), .port_off(port_off), .irq(irq), .irq_n(irq_n));
    // Byte comparison
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One classic cycle; ack and data taken at the rising edge, release right after it
    task automatic wb_xfer(input logic [5:0] idx, input logic w, input logic [3:0] s,
                           input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= s;
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        check8("ack", 8'h01, {7'h00, wb_ack_o});
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask
    // Register write
    task automatic wr_reg(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s);
        logic [7:0] q;
        wb_xfer(idx, 1'b1, s, d, q);
    endtask
    // Register read and compare
    task automatic expect_reg(input string what, input logic [5:0] idx, input logic [7:0] e);
        logic [7:0] q;
        wb_xfer(idx, 1'b0, 4'hF, 8'h00, q);
        check8(what, e, q);
    endtask
    // Interrupt pin, sampled mid-cycle
    task automatic expect_pin(input logic e);
        @(negedge ref_clk);
        check8("irq_n", {7'h00, e}, {7'h00, irq_n});
    endtask
    // Reset values, byte lane gating, read-only and unmapped places
    task automatic t_regs();
        expect_reg("fault", IDX_FAULT, FLAGS_RST);
        expect_reg("start", IDX_START, FLAGS_RST);
        expect_reg("clamp12", IDX_CLAMP12, CLAMP_RST);
        expect_reg("unmapped", 6'h3F, 8'h00);
        wr_reg(IDX_MASK, 8'hA5, 4'hE);
        expect_reg("mask lane", IDX_MASK, MASK_RST);
        wr_reg(IDX_MASK, 8'hA5, 4'hF);
        expect_reg("mask", IDX_MASK, 8'hA5);
        wr_reg(IDX_FAULT, 8'hFF, 4'hF);
        expect_reg("fault ro", IDX_FAULT, 8'h00);
        wr_reg(IDX_START, 8'hFF, 4'hF);
        expect_reg("start ro", IDX_START, 8'h00);
        wr_reg(IDX_MASK, 8'h00, 4'hF);
        $display("test regs done");
    endtask
    // Overload on port 2, plain reads then a clearing read
    task automatic t_trip();
        over_trip_pin <= 4'h2;
        repeat (CYC_US + 10) @(posedge ref_clk);
        over_trip_pin <= 4'h0;
        expect_reg("fault trip", IDX_FAULT, 8'h02);
        expect_reg("fault again", IDX_FAULT, 8'h02);
        expect_reg("summary dis", IDX_SUMMARY, 8'h04);
        expect_reg("fault clr", IDX_FAULT_RC, 8'h02);
        expect_reg("fault after", IDX_FAULT, 8'h00);
        expect_reg("summary off", IDX_SUMMARY, 8'h00);
        $display("test trip done");
    endtask
    // Unplug on port 3 with masked and unmasked interrupt
    task automatic t_unplug();
        wr_reg(IDX_MASK, 8'h20, 4'hF);
        under_unplug_pin <= 4'h4;
        repeat (2 * CYC_US + 10) @(posedge ref_clk);
        under_unplug_pin <= 4'h0;
        expect_pin(1'b0);
        expect_reg("fault unplug", IDX_FAULT, 8'h40);
        expect_reg("summary trip", IDX_SUMMARY, 8'h20);
        wr_reg(IDX_MASK, 8'h04, 4'hF);
        expect_pin(1'b1);
        expect_reg("fault clr", IDX_FAULT_RC, 8'h40);
        $display("test unplug done");
    endtask
    // Inrush on port 1, clamps on ports 3 and 4 with different fields
    task automatic t_start();
        wr_reg(IDX_CLAMP34, 8'h0F, 4'hF);
        wr_reg(IDX_MASK, 8'hFF, 4'hF);
        starting_pin <= 4'h1;
        over_inrush_pin <= 4'h1;
        at_clamp_pin <= 4'hC;
        repeat (2 * CYC_US + 10) @(posedge ref_clk);
        starting_pin <= 4'h0;
        over_inrush_pin <= 4'h0;
        expect_reg("start short", IDX_START, 8'h81);
        expect_reg("summary start", IDX_SUMMARY, 8'h40);
        repeat (16 * CYC_US) @(posedge ref_clk);
        at_clamp_pin <= 4'h0;
        expect_reg("start long", IDX_START, 8'hC1);
        expect_pin(1'b0);
        expect_reg("start clr", IDX_START_RC, 8'hC1);
        expect_reg("start after", IDX_START, 8'h00);
        expect_reg("summary none", IDX_SUMMARY, 8'h00);
        check8("ports off", 8'h0F, {4'h0, off_seen});
        wr_reg(IDX_MASK, 8'h00, 4'hF);
        $display("test start done");
    endtask
    // Clearing reads swept across the moment a flag is raised; it must show exactly once
    task automatic t_race();
        for (int k = 0; k < 8; k++) begin
            over_trip_pin <= 4'h1;
            repeat (CYC_US + k) @(posedge ref_clk);
            wb_xfer(IDX_FAULT_RC, 1'b0, 4'hF, 8'h00, rd);
            repeat (CYC_US) @(posedge ref_clk);
            over_trip_pin <= 4'h0;
            wb_xfer(IDX_FAULT_RC, 1'b0, 4'hF, 8'h00, rd2);
            check8("race union", 8'h01, rd | rd2);
            check8("race once", 8'h00, rd & rd2);
            repeat (4) @(posedge ref_clk);
        end
        $display("test race done");
    endtask
    // Clock enable low: a long overload must leave no trace
    task automatic t_freeze();
        ce <= 1'b0;
        over_trip_pin <= 4'h8;
        repeat (CYC_US + 10) @(posedge ref_clk);
        over_trip_pin <= 4'h0;
        repeat (4) @(posedge ref_clk);
        ce <= 1'b1;
        expect_reg("fault frozen", IDX_FAULT, 8'h00);
        $display("test freeze done");
    endtask
    // Counts and verdict
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        powered_pin <= 4'hF;
        t_regs();
        t_freeze();
        t_trip();
        t_unplug();
        t_start();
        t_race();
        print_verdict();
    end
    // Watchdog, well beyond the roughly 1200 cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
